// [src/fsg_guard.sv]
// flash self-programming section guard with axi4-lite registers
// assumes the core drives one-cycle store/load strobes with word address
`timescale 1ns/1ps
`default_nettype none
module fsg_guard #(
    parameter int PROG_CYC = fsg_pkg::PROG_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [11:0] pc_addr,
    input wire logic store_req,
    input wire logic [11:0] store_addr,
    input wire logic [7:0] store_low_data,
    input wire logic load_req,
    input wire logic [11:0] load_addr,
    input wire logic ext_lock_we,
    input wire logic [3:0] ext_lock_data,
    input wire logic chip_erase,
    input wire logic [1:0] boot_size_fuses,
    output logic core_halt,
    output logic rw_block,
    output logic flash_erase_go,
    output logic flash_write_go,
    output logic flash_load_go,
    output logic load_deny,
    output logic irq_mask
);
    // ========================================
    // region decode
    logic [11:0] boot_base;
    logic pc_in_boot, load_in_boot, store_in_boot, store_in_halt;
    always_comb
    begin
        case (boot_size_fuses)
            2'd0: boot_base = fsg_pkg::BOOT_BASE_0;
            2'd1: boot_base = fsg_pkg::BOOT_BASE_1;
            2'd2: boot_base = fsg_pkg::BOOT_BASE_2;
            default: boot_base = fsg_pkg::BOOT_BASE_3;
        endcase
    end
    // every boot base sits at or above the halting base
    assign pc_in_boot = pc_addr >= boot_base;
    assign load_in_boot = load_addr >= boot_base;
    assign store_in_boot = store_addr >= boot_base;
    assign store_in_halt = store_addr >= fsg_pkg::HALT_BASE;

    // ========================================
    // registers and state
    logic [4:0] cmd_reg, cmd_next;
    logic [3:0] lock_reg, lock_next;
    logic vec_boot_reg, vec_boot_next;
    logic busy_reg, busy_next;
    logic halt_reg, halt_next;
    logic [2:0] win_reg, win_next;
    logic [15:0] cnt_reg, cnt_next;
    fsg_pkg::fsg_state_t st_reg, st_next;
    logic ew_go_reg, ew_go_next, ww_go_reg, ww_go_next;
    logic ld_go_reg, ld_go_next, deny_reg, deny_next;
    logic irq_reg, irq_next;

    fsg_lock_if app_if();
    fsg_lock_if boot_if();
    // app pair sits in bits 1:0, boot pair in bits 3:2; separate fields
    assign app_if.pair = lock_reg[1:0];
    assign app_if.run_other = pc_in_boot;
    assign app_if.vec_other = vec_boot_reg;
    assign boot_if.pair = lock_reg[3:2];
    assign boot_if.run_other = ~pc_in_boot;
    assign boot_if.vec_other = ~vec_boot_reg;
    fsg_lock_decode u_app (.lk(app_if.dec));
    fsg_lock_decode u_boot (.lk(boot_if.dec));

    // ========================================
    // axi4-lite slave
    logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
    logic [7:0] awa_reg, awa_next;
    logic [31:0] wd_reg, wd_next;
    logic bv_reg, bv_next, rv_reg, rv_next;
    logic [1:0] br_reg, br_next, rr_reg, rr_next;
    logic [31:0] rd_reg, rd_next;
    logic do_wr;
    logic [7:0] wa;
    logic [31:0] wd;

    always_comb
    begin
        aw_hold_next = aw_hold_reg;
        w_hold_next = w_hold_reg;
        awa_next = awa_reg;
        wd_next = wd_reg;
        bv_next = bv_reg;
        br_next = br_reg;
        rv_next = rv_reg;
        rr_next = rr_reg;
        rd_next = rd_reg;
        if (s_axi_awvalid && !aw_hold_reg && !bv_reg)
        begin
            aw_hold_next = 1'b1;
            awa_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_hold_reg && !bv_reg)
        begin
            w_hold_next = 1'b1;
            wd_next = s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
        end
        do_wr = aw_hold_reg && w_hold_reg;
        wa = awa_reg;
        wd = wd_reg;
        if (do_wr)
        begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bv_next = 1'b1;
            br_next = (wa == fsg_pkg::CTRL_OFFS || wa == fsg_pkg::LOCK_OFFS
                || wa == fsg_pkg::STAT_OFFS || wa == fsg_pkg::CFG_OFFS)
                ? fsg_pkg::BRESP_OKAY : fsg_pkg::BRESP_SLVERR;
        end
        if (bv_reg && s_axi_bready)
            bv_next = 1'b0;
        if (rv_reg && s_axi_rready)
            rv_next = 1'b0;
        if (s_axi_arvalid && !rv_reg)
        begin
            rv_next = 1'b1;
            rr_next = fsg_pkg::BRESP_OKAY;
            case (s_axi_araddr)
                fsg_pkg::CTRL_OFFS: rd_next = {24'h00_0000, 1'b0, busy_reg,
                    1'b0, cmd_reg};
                fsg_pkg::LOCK_OFFS: rd_next = {28'h000_0000, lock_reg};
                fsg_pkg::STAT_OFFS: rd_next = {28'h000_0000, irq_reg,
                    halt_reg, st_reg};
                fsg_pkg::CFG_OFFS: rd_next = {31'h0000_0000, vec_boot_reg};
                default:
                begin
                    rd_next = 32'h0000_0000;
                    rr_next = fsg_pkg::BRESP_SLVERR;
                end
            endcase
        end
    end

    // ========================================
    // store/load sequencer
    always_comb
    begin
        cmd_next = cmd_reg;
        lock_next = lock_reg;
        vec_boot_next = vec_boot_reg;
        busy_next = busy_reg;
        halt_next = halt_reg;
        win_next = win_reg;
        cnt_next = cnt_reg;
        st_next = st_reg;
        ew_go_next = 1'b0;
        ww_go_next = 1'b0;
        ld_go_next = 1'b0;
        deny_next = 1'b0;
        irq_next = pc_in_boot ? boot_if.irq_mask : app_if.irq_mask;
        case (st_reg)
            fsg_pkg::FSG_IDLE:
            begin
                // only the five legal codes arm the store
                if (do_wr && wa == fsg_pkg::CTRL_OFFS &&
                    (wd[4:0] == fsg_pkg::CMD_LOAD ||
                     wd[4:0] == fsg_pkg::CMD_ERASE ||
                     wd[4:0] == fsg_pkg::CMD_WRITE ||
                     wd[4:0] == fsg_pkg::CMD_LOCK ||
                     wd[4:0] == fsg_pkg::CMD_REEN))
                begin
                    cmd_next = wd[4:0];
                    win_next = 3'(fsg_pkg::ENABLE_WINDOW);
                    st_next = fsg_pkg::FSG_ARMED;
                end
            end
            fsg_pkg::FSG_ARMED:
            begin
                // store from app region is disabled: times out
                if (store_req && pc_in_boot)
                begin
                    st_next = fsg_pkg::FSG_IDLE;
                    cmd_next = 5'h00;
                    case (cmd_reg)
                        fsg_pkg::CMD_LOAD:
                        begin
                            ld_go_next = 1'b1;
                            busy_next = 1'b0;
                        end
                        fsg_pkg::CMD_REEN: busy_next = 1'b0;
                        fsg_pkg::CMD_LOCK:
                            // only clears toward programmed (0)
                            lock_next = lock_reg & store_low_data[5:2];
                        default:
                        begin
                            // general lock modes are not inputs here
                            if ((store_in_boot && boot_if.store_block) ||
                                (!store_in_boot && app_if.store_block))
                                deny_next = 1'b1;
                            else
                            begin
                                cmd_next = cmd_reg;
                                st_next = fsg_pkg::FSG_PROG;
                                cnt_next = 16'(PROG_CYC);
                                ew_go_next = cmd_reg == fsg_pkg::CMD_ERASE;
                                ww_go_next = cmd_reg == fsg_pkg::CMD_WRITE;
                                halt_next = store_in_halt;
                                if (!store_in_halt)
                                    busy_next = 1'b1;
                            end
                        end
                    endcase
                end
                else if (win_reg == 3'd1)
                begin
                    st_next = fsg_pkg::FSG_IDLE;
                    cmd_next = 5'h00;
                end
                else
                    win_next = win_reg - 3'd1;
            end
            fsg_pkg::FSG_PROG:
            begin
                if (cnt_reg == 16'd1)
                begin
                    st_next = fsg_pkg::FSG_IDLE;
                    cmd_next = 5'h00;
                    halt_next = 1'b0;
                end
                else
                    cnt_next = cnt_reg - 16'd1;
            end
            default: st_next = fsg_pkg::FSG_IDLE;
        endcase
        if (do_wr && wa == fsg_pkg::CFG_OFFS)
            vec_boot_next = wd[0];
        if (ext_lock_we)
            lock_next = lock_next & ext_lock_data;
        if (chip_erase)
            lock_next = fsg_pkg::LOCK_RESET;
        // blocked loads of other region and loads below the halting base while busy
        if (load_req)
        begin
            if ((load_in_boot && boot_if.load_block) ||
                (!load_in_boot && app_if.load_block))
                deny_next = 1'b1;
            else if (!(busy_reg && load_addr < fsg_pkg::HALT_BASE))
                ld_go_next = 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awa_reg <= 8'h00;
            wd_reg <= 32'h0000_0000;
            bv_reg <= 1'b0;
            br_reg <= 2'b00;
            rv_reg <= 1'b0;
            rr_reg <= 2'b00;
            rd_reg <= 32'h0000_0000;
            cmd_reg <= 5'h00;
            lock_reg <= fsg_pkg::LOCK_RESET;
            vec_boot_reg <= 1'b0;
            busy_reg <= 1'b0;
            halt_reg <= 1'b0;
            win_reg <= 3'd0;
            cnt_reg <= 16'h0000;
            st_reg <= fsg_pkg::FSG_IDLE;
            ew_go_reg <= 1'b0;
            ww_go_reg <= 1'b0;
            ld_go_reg <= 1'b0;
            deny_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            aw_hold_reg <= aw_hold_next;
            w_hold_reg <= w_hold_next;
            awa_reg <= awa_next;
            wd_reg <= wd_next;
            bv_reg <= bv_next;
            br_reg <= br_next;
            rv_reg <= rv_next;
            rr_reg <= rr_next;
            rd_reg <= rd_next;
            cmd_reg <= cmd_next;
            lock_reg <= lock_next;
            vec_boot_reg <= vec_boot_next;
            busy_reg <= busy_next;
            halt_reg <= halt_next;
            win_reg <= win_next;
            cnt_reg <= cnt_next;
            st_reg <= st_next;
            ew_go_reg <= ew_go_next;
            ww_go_reg <= ww_go_next;
            ld_go_reg <= ld_go_next;
            deny_reg <= deny_next;
            irq_reg <= irq_next;
        end
    end

    assign s_axi_awready = ~aw_hold_reg & ~bv_reg;
    assign s_axi_wready = ~w_hold_reg & ~bv_reg;
    assign s_axi_bvalid = bv_reg;
    assign s_axi_bresp = br_reg;
    assign s_axi_arready = ~rv_reg;
    assign s_axi_rvalid = rv_reg;
    assign s_axi_rdata = rd_reg;
    assign s_axi_rresp = rr_reg;
    assign core_halt = halt_reg;
    assign rw_block = busy_reg;
    assign flash_erase_go = ew_go_reg;
    assign flash_write_go = ww_go_reg;
    assign flash_load_go = ld_go_reg;
    assign load_deny = deny_reg;
    assign irq_mask = irq_reg;
endmodule : fsg_guard
`default_nettype wire

// [src/fsg_pkg.sv]
// constants and types for the flash self-programming section guard
// assumes a word-addressed program flash of FLASH_AW bits behind the core
package fsg_pkg;

    localparam int FLASH_AW = 12;
    // word address where the halting region starts
    localparam logic [11:0] HALT_BASE = 12'h0C00;
    // boot region starts, indexed by boot size fuses
    localparam logic [11:0] BOOT_BASE_0 = 12'h0C00;
    localparam logic [11:0] BOOT_BASE_1 = 12'h0E00;
    localparam logic [11:0] BOOT_BASE_2 = 12'h0F00;
    localparam logic [11:0] BOOT_BASE_3 = 12'h0F80;
    localparam int ENABLE_WINDOW = 4;
    localparam int PROG_TIME_NS = 4000;
    localparam int CLK_NS = 5;
    localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;

    // register offsets
    localparam logic [7:0] CTRL_OFFS = 8'h00;
    localparam logic [7:0] LOCK_OFFS = 8'h04;
    localparam logic [7:0] STAT_OFFS = 8'h08;
    localparam logic [7:0] CFG_OFFS = 8'h0C;

    // control register bit positions
    localparam int BIT_ENABLE = 0;
    localparam int BIT_ERASE = 1;
    localparam int BIT_WRITE = 2;
    localparam int BIT_LOCKSET = 3;
    localparam int BIT_REENABLE = 4;
    localparam int BIT_BUSY = 6;

    // command codes in the low five bits
    localparam logic [4:0] CMD_LOAD = 5'h01;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_LOCK = 5'h09;
    localparam logic [4:0] CMD_REEN = 5'h11;

    localparam logic [3:0] LOCK_RESET = 4'hF;
    localparam logic [1:0] BRESP_OKAY = 2'b00;
    localparam logic [1:0] BRESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        FSG_IDLE = 2'b00,
        FSG_ARMED = 2'b01,
        FSG_PROG = 2'b11
    } fsg_state_t;

endpackage : fsg_pkg

// [src/fsg_lock_if.sv]
// carrier between the guard core and its lock decode
// assumes single clock domain, combinational decode
`timescale 1ns/1ps
`default_nettype none
interface fsg_lock_if;
    logic [1:0] pair;
    logic vec_other;
    logic run_other;
    logic store_block;
    logic load_block;
    logic irq_mask;
    modport core (output pair, output vec_other, output run_other,
        input store_block, input load_block, input irq_mask);
    modport dec (input pair, input vec_other, input run_other,
        output store_block, output load_block, output irq_mask);
endinterface : fsg_lock_if
`default_nettype wire

// [src/fsg_lock_decode.sv]
// one lock pair decode, used once per flash region
// assumes pair is high bit first, 1 means unprogrammed
`timescale 1ns/1ps
`default_nettype none
module fsg_lock_decode (
    fsg_lock_if.dec lk
);
    always_comb
    begin
        // pair 11 lifts every restriction
        lk.store_block = 1'b0;
        if (!lk.pair[0])
            lk.store_block = 1'b1;
        // load from the other region blocked for pair 0x
        lk.load_block = ~lk.pair[1] & lk.run_other;
        lk.irq_mask = ~lk.pair[1] & lk.vec_other;
    end
endmodule : fsg_lock_decode
`default_nettype wire

// [tb/fsg_guard_assertions.sv]
// assertions on the guard's core side and write answer
// assumes bind onto fsg_guard with the same PROG_CYC
`timescale 1ns/1ps
`default_nettype none
module fsg_guard_assertions #(
    parameter int PROG_CYC = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] pc_addr,
    input wire logic store_req,
    input wire logic [11:0] store_addr,
    input wire logic load_req,
    input wire logic [11:0] load_addr,
    input wire logic core_halt,
    input wire logic rw_block,
    input wire logic flash_erase_go,
    input wire logic flash_write_go,
    input wire logic flash_load_go,
    input wire logic load_deny,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp
);
    logic [15:0] halt_cnt_reg;
    wire logic go = flash_erase_go | flash_write_go;
    // ========
    // cycles the core has been halted so far
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !core_halt)
            halt_cnt_reg <= 16'h0000;
        else
            halt_cnt_reg <= halt_cnt_reg + 16'h0001;
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ========
    // properties
    a_conc_busy:
    assert property (go && $past(store_addr) < fsg_pkg::HALT_BASE
        |-> rw_block && !core_halt) else $error("concurrent program halted");
    a_halt_prog:
    assert property (go && $past(store_addr) >= fsg_pkg::HALT_BASE
        |-> core_halt) else $error("halting program did not halt");
    a_halt_len:
    assert property ($fell(core_halt) && $past(aresetn)
        |-> halt_cnt_reg == 16'(PROG_CYC)) else $error("halt length");
    a_go_from_boot:
    assert property (go |-> $past(store_req)
        && $past(pc_addr) >= fsg_pkg::HALT_BASE) else $error("stray go");
    a_busy_clear:
    assert property ($fell(rw_block) && $past(aresetn)
        |-> $past(store_req)) else $error("busy cleared by itself");
    a_load_drop:
    assert property (load_req && load_addr < fsg_pkg::HALT_BASE
        && rw_block |=> !flash_load_go) else $error("busy load passed");
    a_deny_quiet:
    assert property (load_deny |-> !go && !flash_load_go)
        else $error("refused access went ahead");
    a_b_once:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
endmodule : fsg_guard_assertions
`default_nettype wire

// [tb/fsg_core_model.sv]
// processor core stand-in driving store and load strobes
// assumes its tasks are called just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module fsg_core_model (
    input wire logic aclk,
    output logic [11:0] pc_addr,
    output logic store_req,
    output logic [11:0] store_addr,
    output logic [7:0] store_low_data,
    output logic load_req,
    output logic [11:0] load_addr
);
    initial
    begin
        pc_addr = 12'hF80;
        store_req = 1'b0;
        load_req = 1'b0;
        store_addr = 12'h000;
        load_addr = 12'h000;
        store_low_data = 8'h00;
    end
    // ========
    // one strobe; released lines show inverted data, not a stale copy
    task automatic op(input logic st, input logic [11:0] a,
        input logic [7:0] d);
        @(posedge aclk);
        store_req <= st;
        load_req <= !st;
        store_addr <= a;
        load_addr <= a;
        store_low_data <= d;
        @(posedge aclk);
        store_req <= 1'b0;
        load_req <= 1'b0;
        store_addr <= ~a;
        load_addr <= ~a;
        store_low_data <= ~d;
        #1;
    endtask : op
    task automatic set_pc(input logic [11:0] p);
        @(posedge aclk);
        pc_addr <= p;
    endtask : set_pc
endmodule : fsg_core_model
`default_nettype wire

// [tb/fsg_guard_tb.sv]
// bench for the section guard: bus tasks, core model, lock sweep
// assumes fsg_pkg and the design compiled first; PROG_CYC cut to 8
`timescale 1ns/1ps
`default_nettype none
module fsg_guard_tb;
    localparam int PC = 8;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, ext_we = 1'b0;
    logic cerase = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, sdata;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [1:0] fuses = 2'b00, bresp, rresp;
    logic [3:0] ext_data = 4'hF;
    logic [11:0] pc, saddr, laddr;
    logic sreq, lreq, halt, busy, ego, wgo, lgo, deny, irq;
    int error_cnt = 0, tests_run = 0, cyc = 0;
    initial forever #2.5 aclk = ~aclk;
    fsg_guard #(.PROG_CYC(PC)) dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pc_addr(pc), .store_req(sreq),
        .store_addr(saddr), .store_low_data(sdata), .load_req(lreq),
        .load_addr(laddr), .ext_lock_we(ext_we), .ext_lock_data(ext_data),
        .chip_erase(cerase), .boot_size_fuses(fuses), .core_halt(halt),
        .rw_block(busy), .flash_erase_go(ego), .flash_write_go(wgo),
        .flash_load_go(lgo), .load_deny(deny), .irq_mask(irq)
    );
    fsg_core_model core (
        .aclk(aclk), .pc_addr(pc), .store_req(sreq), .store_addr(saddr),
        .store_low_data(sdata), .load_req(lreq), .load_addr(laddr)
    );
    // ========
    // tasks
    task automatic end_sim();
        if (error_cnt == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
        logic ta, tw, tr, done;
        @(posedge aclk);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awvalid <= wr;
        wvalid <= wr;
        bready <= wr;
        arvalid <= !wr;
        rready <= !wr;
        done = 1'b0;
        while (!done)
        begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tr = arvalid && arready;
            done = (wr ? bvalid : rvalid) === 1'b1;
            r = wr ? bresp : rresp;
            q = rdata;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tr) arvalid <= 1'b0;
        end
        bready <= 1'b0;
        rready <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic [1:0] r;
        bus(1'b1, a, d, q, r);
        check(32'(r), 32'(fsg_pkg::BRESP_OKAY));
    endtask : wr
    task automatic arm(input logic [4:0] c);
        wr(fsg_pkg::CTRL_OFFS, 32'(c));
    endtask : arm
    task automatic clr(input logic [4:0] c);
        arm(c);
        core.op(1'b1, 12'h000, 8'h00);
    endtask : clr
    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask : wt
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            error_cnt++;
            end_sim();
        end
    end
    // ========
    // main sequence
    initial
    begin
        logic [31:0] q;
        logic [1:0] r;
        logic [3:0] lk;
        int n;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        bus(1'b0, fsg_pkg::LOCK_OFFS, 32'h0000_0000, q, r);
        check(q, 32'h0000_000F);
        bus(1'b1, 8'h20, 32'h0000_0000, q, r);
        check(32'(r), 32'(fsg_pkg::BRESP_SLVERR));
        bus(1'b0, 8'h20, 32'h0000_0000, q, r);
        check(32'(r), 32'(fsg_pkg::BRESP_SLVERR));
        // an illegal code must leave the store unarmed
        arm(5'h07);
        bus(1'b0, fsg_pkg::CTRL_OFFS, 32'h0000_0000, q, r);
        check(q, 32'h0000_0000);
        for (int k = 0; k < 2; k++)
        begin
            arm(fsg_pkg::CMD_ERASE);
            core.op(1'b1, 12'h100, 8'h00);
            check(32'(ego), 32'h0000_0001);
            check(32'(halt), 32'h0000_0000);
            bus(1'b0, fsg_pkg::CTRL_OFFS, 32'h0000_0000, q, r);
            check(q & 32'h0000_0040, 32'h0000_0040);
            core.op(1'b0, 12'h100, 8'h00);
            check(32'(lgo), 32'h0000_0000);
            core.op(1'b0, 12'hC80, 8'h00);
            check(32'(lgo), 32'h0000_0001);
            wt(PC + 2);
            check(32'(busy), 32'h0000_0001);
            if (k == 0)
                clr(fsg_pkg::CMD_REEN);
            else
                clr(fsg_pkg::CMD_LOAD);
            check(32'(busy), 32'h0000_0000);
        end
        arm(fsg_pkg::CMD_WRITE);
        core.op(1'b1, 12'hD00, 8'h00);
        check(32'(wgo), 32'h0000_0001);
        n = 0;
        while (halt === 1'b1)
        begin
            wt(1);
            n++;
        end
        check(32'(n), 32'(PC));
        core.set_pc(12'h100);
        arm(fsg_pkg::CMD_ERASE);
        core.op(1'b1, 12'h200, 8'h00);
        check(32'(ego), 32'h0000_0000);
        for (int s = 0; s < 2; s++)
            for (int p = 0; p < 4; p++)
            begin
                fuses <= 2'(p);
                cerase <= 1'b1;
                @(posedge aclk);
                cerase <= 1'b0;
                bus(1'b0, fsg_pkg::LOCK_OFFS, 32'h0000_0000, q, r);
                check(q, 32'h0000_000F);
                core.set_pc(12'hF80);
                if (s == 0)
                begin
                    arm(fsg_pkg::CMD_LOCK);
                    core.op(1'b1, 12'h3A5, {4'hF, 2'(p), 2'b11});
                end
                else
                begin
                    ext_we <= 1'b1;
                    ext_data <= {2'(p), 2'b11};
                    @(posedge aclk);
                    ext_we <= 1'b0;
                end
                lk = (s == 1) ? {2'(p), 2'b11} : {2'b11, 2'(p)};
                bus(1'b0, fsg_pkg::LOCK_OFFS, 32'h0000_0000, q, r);
                check(q, 32'(lk));
                arm(fsg_pkg::CMD_WRITE);
                core.op(1'b1, (s == 1) ? 12'hFC0 : 12'h200, 8'h00);
                if (s == 0)
                    check(32'(wgo), 32'(p[0]));
                else
                    check(32'(wgo), 32'(p[0]));
                check(32'(deny), 32'(!p[0]));
                if (p[0] == 1'b1)
                begin
                    wt(PC + 2);
                    if (s == 0)
                        clr(fsg_pkg::CMD_REEN);
                end
                core.set_pc((s == 1) ? 12'h100 : 12'hF80);
                core.op(1'b0, (s == 1) ? 12'hFC0 : 12'h200, 8'h00);
                check(32'(lgo), 32'(p[1]));
                check(32'(deny), 32'(!p[1]));
                wr(fsg_pkg::CFG_OFFS, 32'(s == 0));
                core.set_pc((s == 1) ? 12'hF80 : 12'h100);
                wt(2);
                check(32'(irq), 32'(!p[1]));
            end
        end_sim();
    end
endmodule : fsg_guard_tb
bind fsg_guard fsg_guard_assertions #(.PROG_CYC(PROG_CYC)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .pc_addr(pc_addr),
    .store_req(store_req), .store_addr(store_addr), .load_req(load_req),
    .load_addr(load_addr), .core_halt(core_halt), .rw_block(rw_block),
    .flash_erase_go(flash_erase_go), .flash_write_go(flash_write_go),
    .flash_load_go(flash_load_go), .load_deny(load_deny),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp)
);
`default_nettype wire
